// ==== rtl/bit_unit_pkg.sv ====
package bit_unit_pkg;
    localparam int OPC_W = 4;
    localparam logic [7:0] WO_READ_VALUE = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    typedef enum logic [3:0] {
        bit_force_one, bit_force_zero, bit_invert, bit_test_to_zero_flag,
        carry_and_bit, carry_and_inverted_bit, carry_or_bit, carry_or_inverted_bit,
        carry_xor_bit, carry_xor_inverted_bit, bit_load_to_carry,
        inverted_bit_load_to_carry, carry_store_to_bit, inverted_carry_store_to_bit
    } bit_op_t;
endpackage : bit_unit_pkg

// ==== rtl/bit_alu.sv ====
`timescale 1ns/10ps
// combinational bit operation on one byte
module bit_alu (
    input wire logic [3:0] op_in,
    input wire logic [7:0] data_in,
    input wire logic [2:0] bitno_in,
    input wire logic carry_in,
    output logic [7:0] data_out,
    output logic carry_out,
    output logic zero_out,
    output logic writes_out
);
    logic sel;
    bit_unit_pkg::bit_op_t op;
    assign op = bit_unit_pkg::bit_op_t'(op_in);
    assign sel = data_in[bitno_in];
    // per-op result; untouched carry passes through, zero_out is 0 unless testing
    always_comb begin
        data_out = data_in;
        carry_out = carry_in;
        zero_out = 1'b0;
        writes_out = 1'b0;
        case (op)
            bit_unit_pkg::bit_force_one: begin
                data_out[bitno_in] = 1'b1;
                writes_out = 1'b1;
            end
            bit_unit_pkg::bit_force_zero: begin
                data_out[bitno_in] = 1'b0;
                writes_out = 1'b1;
            end
            bit_unit_pkg::bit_invert: begin
                data_out[bitno_in] = ~sel;
                writes_out = 1'b1;
            end
            bit_unit_pkg::bit_test_to_zero_flag: zero_out = ~sel;
            bit_unit_pkg::carry_and_bit: carry_out = carry_in & sel;
            bit_unit_pkg::carry_and_inverted_bit: carry_out = carry_in & ~sel;
            bit_unit_pkg::carry_or_bit: carry_out = carry_in | sel;
            bit_unit_pkg::carry_or_inverted_bit: carry_out = carry_in | ~sel;
            bit_unit_pkg::carry_xor_bit: carry_out = carry_in ^ sel;
            bit_unit_pkg::carry_xor_inverted_bit: carry_out = carry_in ^ ~sel;
            bit_unit_pkg::bit_load_to_carry: carry_out = sel;
            bit_unit_pkg::inverted_bit_load_to_carry: carry_out = ~sel;
            bit_unit_pkg::carry_store_to_bit: begin
                data_out[bitno_in] = carry_in;
                writes_out = 1'b1;
            end
            bit_unit_pkg::inverted_carry_store_to_bit: begin
                data_out[bitno_in] = ~carry_in;
                writes_out = 1'b1;
            end
            default: begin
                data_out = data_in;
            end
        endcase
    end
endmodule : bit_alu

// ==== rtl/bit_unit.sv ====
`timescale 1ns/10ps
// bit manipulation execution unit with memory read-modify-write sequencer
module bit_unit (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic [3:0] op_in,
    input wire logic use_reg_bitno_in,
    input wire logic [2:0] imm_bitno_in,
    input wire logic [7:0] reg_bitno_in,
    input wire logic mem_operand_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] reg_data_in,
    input wire logic carry_in,
    input wire logic zero_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic mem_wo_in,
    input wire logic mem_ack_in,
    output logic busy_out,
    output logic done_out,
    output logic illegal_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_we_out,
    output logic carry_out,
    output logic zero_out,
    output logic flags_we_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_rd_out,
    output logic mem_wr_out
);
    typedef enum logic [1:0] {idle_s, read_s, write_s} seq_state_t;
    seq_state_t state;
    bit_unit_pkg::bit_op_t op;
    bit_unit_pkg::bit_op_t cur_op;
    logic imm_only;
    logic [2:0] sel_bitno;
    logic [2:0] bitno;
    logic carry_q;
    logic zero_q;
    logic [7:0] alu_src;
    logic [7:0] alu_data;
    logic alu_carry;
    logic alu_zero;
    logic alu_writes;
    logic [7:0] read_byte;

    assign op = bit_unit_pkg::bit_op_t'(op_in);
    // inverted forms accept only an immediate bit number
    assign imm_only = (op == bit_unit_pkg::carry_and_inverted_bit)
        || (op == bit_unit_pkg::carry_or_inverted_bit)
        || (op == bit_unit_pkg::carry_xor_inverted_bit)
        || (op == bit_unit_pkg::inverted_bit_load_to_carry)
        || (op == bit_unit_pkg::inverted_carry_store_to_bit);
    assign sel_bitno = use_reg_bitno_in ? reg_bitno_in[2:0] : imm_bitno_in;

    // write-only locations read back as all ones
    assign read_byte = mem_wo_in ? bit_unit_pkg::WO_READ_VALUE : mem_rdata_in;
    assign alu_src = (state == read_s) ? read_byte : reg_data_in;

    bit_alu u_alu (
        .op_in(state == read_s ? cur_op : op),
        .data_in(alu_src),
        .bitno_in(state == read_s ? bitno : sel_bitno),
        .carry_in(state == read_s ? carry_q : carry_in),
        .data_out(alu_data),
        .carry_out(alu_carry),
        .zero_out(alu_zero),
        .writes_out(alu_writes)
    );

    // sequencer: idle, read byte, write byte back
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= idle_s;
            cur_op <= bit_unit_pkg::bit_force_one;
            bitno <= 3'h0;
            carry_q <= 1'b0;
            zero_q <= 1'b0;
            mem_addr_out <= bit_unit_pkg::ADDR_RESET;
        end else begin
            case (state)
                idle_s: begin
                    if (start_in && mem_operand_in && !(imm_only && use_reg_bitno_in)) begin
                        state <= read_s;
                        cur_op <= op;
                        bitno <= sel_bitno;
                        carry_q <= carry_in;
                        zero_q <= zero_in;
                        mem_addr_out <= addr_in;
                    end
                end
                read_s: begin
                    if (mem_ack_in) begin
                        state <= alu_writes ? write_s : idle_s;
                    end
                end
                write_s: begin
                    if (mem_ack_in) begin
                        state <= idle_s;
                    end
                end
                default: state <= idle_s;
            endcase
        end
    end

    // modified byte held for the write step at the same address
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mem_wdata_out <= bit_unit_pkg::DATA_RESET;
        end else if (state == read_s && mem_ack_in) begin
            mem_wdata_out <= alu_data;
        end
    end

    // register operands complete in one cycle; results registered
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_wdata_out <= bit_unit_pkg::DATA_RESET;
            reg_we_out <= 1'b0;
            carry_out <= 1'b0;
            zero_out <= 1'b0;
            flags_we_out <= 1'b0;
            done_out <= 1'b0;
            illegal_out <= 1'b0;
        end else begin
            reg_we_out <= 1'b0;
            flags_we_out <= 1'b0;
            done_out <= 1'b0;
            illegal_out <= 1'b0;
            if (state == idle_s && start_in) begin
                if (imm_only && use_reg_bitno_in) begin
                    illegal_out <= 1'b1;
                    done_out <= 1'b1;
                end else if (!mem_operand_in) begin
                    reg_wdata_out <= alu_data;
                    reg_we_out <= alu_writes;
                    carry_out <= alu_carry;
                    zero_out <= (op == bit_unit_pkg::bit_test_to_zero_flag) ? alu_zero : zero_in;
                    flags_we_out <= 1'b1;
                    done_out <= 1'b1;
                end
            end else if ((state == read_s && mem_ack_in && !alu_writes)
                || (state == write_s && mem_ack_in)) begin
                carry_out <= (state == read_s) ? alu_carry : carry_q;
                zero_out <= (state == read_s && cur_op == bit_unit_pkg::bit_test_to_zero_flag)
                    ? alu_zero : zero_q;
                flags_we_out <= 1'b1;
                done_out <= 1'b1;
            end
        end
    end

    // bus strobes follow the sequencer state
    assign mem_rd_out = (state == read_s);
    assign mem_wr_out = (state == write_s);
    assign busy_out = (state != idle_s);

    // check helpers: register-path launch, selected bit, altering ops
    logic reg_go;
    logic reg_bit;
    logic alters_op;
    assign reg_go = (state == idle_s) && start_in && !mem_operand_in
        && !(imm_only && use_reg_bitno_in);
    assign reg_bit = reg_data_in[sel_bitno];
    assign alters_op = (op == bit_unit_pkg::bit_force_one)
        || (op == bit_unit_pkg::bit_force_zero)
        || (op == bit_unit_pkg::bit_invert)
        || (op == bit_unit_pkg::carry_store_to_bit)
        || (op == bit_unit_pkg::inverted_carry_store_to_bit);

    // memory sequence: read, then write back to the same address
    a_write_after_read: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_wr_out && !$past(mem_wr_out) |-> $past(mem_rd_out) && $past(mem_ack_in))
        else $error("write step not preceded by read step");
    a_readonly_no_write: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_rd_out && mem_ack_in && !alu_writes |=> !mem_wr_out && done_out)
        else $error("read-only op wrote memory");
    a_same_address: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_wr_out && !$past(mem_wr_out) |-> mem_addr_out == $past(mem_addr_out))
        else $error("write address differs from read");
    a_wo_all_ones: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_rd_out && mem_ack_in && mem_wo_in && alu_writes
        |=> (mem_wdata_out | (8'h01 << bitno)) == 8'hFF)
        else $error("write-only read not all ones");
    // register path: each operation checked one cycle after launch
    a_force_one: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        state == idle_s && start_in && !mem_operand_in && op == bit_unit_pkg::bit_force_one
        |=> reg_we_out && reg_wdata_out[$past(sel_bitno)] == 1'b1)
        else $error("force-one failed");
    a_force_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        state == idle_s && start_in && !mem_operand_in && op == bit_unit_pkg::bit_force_zero
        |=> reg_wdata_out[$past(sel_bitno)] == 1'b0)
        else $error("force-zero failed");
    a_test_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        state == idle_s && start_in && !mem_operand_in
        && op == bit_unit_pkg::bit_test_to_zero_flag
        |=> zero_out == !$past(reg_data_in[sel_bitno]) && carry_out == $past(carry_in))
        else $error("test zero flag wrong");
    a_inv_imm_only: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        state == idle_s && start_in && imm_only && use_reg_bitno_in
        |=> illegal_out && !busy_out && !reg_we_out)
        else $error("inverted op took register bit number");
    a_and_carry: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        state == idle_s && start_in && !mem_operand_in && op == bit_unit_pkg::carry_and_bit
        |=> carry_out == ($past(carry_in) & $past(reg_data_in[sel_bitno])) && !reg_we_out)
        else $error("carry and wrong");
    a_invert_bit: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::bit_invert
        |=> reg_we_out && (reg_wdata_out ^ $past(reg_data_in)) == (8'h01 << $past(sel_bitno)))
        else $error("invert did not flip exactly one bit");
    a_reg_bitno: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && use_reg_bitno_in && op == bit_unit_pkg::bit_force_one
        |=> reg_wdata_out[$past(reg_bitno_in[2:0])] == 1'b1)
        else $error("register bit number not used");
    a_and_inverted: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::carry_and_inverted_bit
        |=> carry_out == ($past(carry_in) & !$past(reg_bit)) && !reg_we_out)
        else $error("carry and inverted wrong");
    a_or_carry: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::carry_or_bit
        |=> carry_out == ($past(carry_in) | $past(reg_bit)) && !reg_we_out)
        else $error("carry or wrong");
    a_or_inverted: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::carry_or_inverted_bit
        |=> carry_out == ($past(carry_in) | !$past(reg_bit)) && !reg_we_out)
        else $error("carry or inverted wrong");
    a_xor_carry: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::carry_xor_bit
        |=> carry_out == ($past(carry_in) ^ $past(reg_bit)) && !reg_we_out)
        else $error("carry xor wrong");
    a_xor_inverted: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::carry_xor_inverted_bit
        |=> carry_out == ($past(carry_in) ^ !$past(reg_bit)) && !reg_we_out)
        else $error("carry xor inverted wrong");
    a_load_carry: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::bit_load_to_carry
        |=> carry_out == $past(reg_bit) && !reg_we_out)
        else $error("bit load wrong");
    a_load_inverted: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::inverted_bit_load_to_carry
        |=> carry_out == !$past(reg_bit) && !reg_we_out)
        else $error("inverted bit load wrong");
    a_store_carry: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::carry_store_to_bit
        |=> reg_we_out && reg_wdata_out[$past(sel_bitno)] == $past(carry_in))
        else $error("carry store wrong");
    a_store_inverted: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op == bit_unit_pkg::inverted_carry_store_to_bit
        |=> reg_we_out && reg_wdata_out[$past(sel_bitno)] == !$past(carry_in))
        else $error("inverted carry store wrong");

    // flags outside each operation's reach pass through unchanged; register write, completion, refusal and bus use checks
    a_carry_kept: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && (alters_op || op == bit_unit_pkg::bit_test_to_zero_flag)
        |=> carry_out == $past(carry_in) && flags_we_out)
        else $error("carry changed by a non-carry op");
    a_zero_kept: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go && op != bit_unit_pkg::bit_test_to_zero_flag
        |=> zero_out == $past(zero_in))
        else $error("zero flag changed by a non-test op");
    a_reg_we_match: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go
        |=> reg_we_out == $past(alters_op) && done_out)
        else $error("register write does not match op");
    a_flags_with_done: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        flags_we_out
        |-> done_out && !illegal_out)
        else $error("flag write without completion");
    a_illegal_idle: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        illegal_out
        |-> done_out && !flags_we_out && !reg_we_out && !busy_out)
        else $error("refused op had side effects");
    a_reg_no_bus: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        reg_go
        |=> !mem_rd_out && !mem_wr_out && !busy_out)
        else $error("register op used the memory bus");

    // memory path: sequence start, single-bit change, flags at the end
    a_mem_start: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        state == idle_s && start_in && mem_operand_in && !(imm_only && use_reg_bitno_in)
        |=> mem_rd_out && !mem_wr_out && mem_addr_out == $past(addr_in))
        else $error("memory op did not start with a read");
    a_mem_one_bit: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_rd_out && mem_ack_in && alu_writes
        |=> ((mem_wdata_out ^ $past(read_byte)) & ~(8'h01 << bitno)) == 8'h00)
        else $error("write-back altered more than one bit");
    a_mem_test_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_rd_out && mem_ack_in && cur_op == bit_unit_pkg::bit_test_to_zero_flag
        |=> done_out && zero_out == !$past(read_byte[bitno]) && carry_out == $past(carry_q))
        else $error("memory test zero flag wrong");
    a_mem_load: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_rd_out && mem_ack_in && cur_op == bit_unit_pkg::bit_load_to_carry
        |=> done_out && carry_out == $past(read_byte[bitno]))
        else $error("memory bit load wrong");
    a_mem_store: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_rd_out && mem_ack_in && cur_op == bit_unit_pkg::carry_store_to_bit
        |=> mem_wr_out && mem_wdata_out[bitno] == carry_q)
        else $error("memory carry store wrong");
    a_mem_store_inv: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_rd_out && mem_ack_in && cur_op == bit_unit_pkg::inverted_carry_store_to_bit
        |=> mem_wr_out && mem_wdata_out[bitno] == !carry_q)
        else $error("memory inverted carry store wrong");
    a_mem_flags_kept: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        mem_wr_out && mem_ack_in
        |=> done_out && carry_out == $past(carry_q) && zero_out == $past(zero_q))
        else $error("flags changed by a write-back op");
endmodule : bit_unit

// ==== tb/bit_bus_model.sv ====
`timescale 1ns/10ps
// byte memory on the operand bus, with wait states and one write-only slot
module bit_bus_model (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [1:0] wait_in,
    input wire logic wo_on_in,
    output logic ack_out,
    output logic [7:0] rdata_out,
    output logic wo_out
);
    logic [7:0] mem [16];
    logic [7:0] writes;
    logic [1:0] cnt;
    // one ack per held request, read data toggles while not valid
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_out <= 1'b0;
            cnt <= 2'h0;
            rdata_out <= 8'h00;
            wo_out <= 1'b0;
            writes <= 8'h00;
        end else begin
            ack_out <= 1'b0;
            wo_out <= 1'b0;
            rdata_out <= ~rdata_out;
            if ((rd_in || wr_in) && !ack_out) begin
                if (cnt == wait_in) begin
                    cnt <= 2'h0;
                    ack_out <= 1'b1;
                    if (wr_in) begin
                        mem[addr_in[3:0]] <= wdata_in;
                        writes <= writes + 8'h01;
                    end else begin
                        rdata_out <= mem[addr_in[3:0]];
                        wo_out <= wo_on_in && (addr_in[3:0] == 4'hF);
                    end
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
endmodule : bit_bus_model

// ==== tb/test_cpu_bit_manipulation_unit.sv ====
`timescale 1ns/10ps
module test_cpu_bit_manipulation_unit;
    logic mclk_in, arst_n_in, start_in, use_reg_bitno_in, mem_operand_in, carry_in, zero_in;
    logic mem_wo_in, mem_ack_in, busy_out, done_out, illegal_out, reg_we_out, wo_on;
    logic carry_out, zero_out, flags_we_out, mem_rd_out, mem_wr_out;
    logic [3:0] op_in;
    logic [2:0] imm_bitno_in;
    logic [1:0] bus_wait;
    logic [7:0] reg_bitno_in, reg_data_in, mem_rdata_in, reg_wdata_out, mem_wdata_out, w0, m0;
    logic [15:0] addr_in, mem_addr_out;
    logic [10:0] e;
    int err_total, cmp_count;
    bit_unit dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .start_in(start_in), .op_in(op_in),
        .use_reg_bitno_in(use_reg_bitno_in), .imm_bitno_in(imm_bitno_in),
        .reg_bitno_in(reg_bitno_in), .mem_operand_in(mem_operand_in), .addr_in(addr_in),
        .reg_data_in(reg_data_in), .carry_in(carry_in), .zero_in(zero_in),
        .mem_rdata_in(mem_rdata_in), .mem_wo_in(mem_wo_in), .mem_ack_in(mem_ack_in),
        .busy_out(busy_out), .done_out(done_out), .illegal_out(illegal_out),
        .reg_wdata_out(reg_wdata_out), .reg_we_out(reg_we_out), .carry_out(carry_out),
        .zero_out(zero_out), .flags_we_out(flags_we_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out));
    bit_bus_model bus (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .rd_in(mem_rd_out),
        .wr_in(mem_wr_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
        .wait_in(bus_wait), .wo_on_in(wo_on), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in),
        .wo_out(mem_wo_in));
    // clock and time-zero values
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // reference result: {byte, carry, zero, writes}
    function automatic logic [10:0] exp_calc(input logic [3:0] op, input logic [7:0] d,
        input logic [2:0] b, input logic c, input logic z);
        logic x;
        x = d[b];
        case (op)
            4'h0: d[b] = 1'b1;
            4'h1: d[b] = 1'b0;
            4'h2: d[b] = ~x;
            4'h3: z = ~x;
            4'h4: c = c & x;
            4'h5: c = c & ~x;
            4'h6: c = c | x;
            4'h7: c = c | ~x;
            4'h8: c = c ^ x;
            4'h9: c = c ^ ~x;
            4'hA: c = x;
            4'hB: c = ~x;
            4'hC: d[b] = c;
            4'hD: d[b] = ~c;
            default: ;
        endcase
        return {d, c, z, (op < 4'h3) || (op > 4'hB)};
    endfunction : exp_calc
    // one instruction: request pulse, then bounded wait for completion
    task automatic do_op(input logic [3:0] op, input logic m, input logic u, input logic [2:0] b,
        input logic [7:0] rb, input logic [7:0] d, input logic [3:0] a, input logic c,
        input logic [1:0] wt, input logic wo);
        int n;
        logic bsy;
        @(posedge mclk_in);
        op_in <= op;
        mem_operand_in <= m;
        use_reg_bitno_in <= u;
        imm_bitno_in <= b;
        reg_bitno_in <= rb;
        reg_data_in <= d;
        addr_in <= {12'h000, a};
        carry_in <= c;
        zero_in <= ~c;
        bus_wait <= wt;
        wo_on <= wo;
        start_in <= 1'b1;
        @(posedge mclk_in);
        start_in <= 1'b0;
        n = 0;
        bsy = 1'b0;
        do begin
            @(negedge mclk_in);
            n++;
            if (n == 1) begin
                bsy = busy_out;
            end
        end while (done_out !== 1'b1 && n < 40);
        chk("done", {15'h0000, done_out}, 16'h0001);
        chk("busy", {15'h0000, bsy}, {15'h0000, m});
    endtask : do_op
    task automatic t_reg_ops;
        for (int op = 0; op < 14; op++) begin
            for (int c = 0; c < 2; c++) begin
                do_op(4'(op), 1'b0, 1'b0, 3'(op), 8'h00, 8'hA5, 4'h0, 1'(c), 2'h0, 1'b0);
                e = exp_calc(4'(op), 8'hA5, 3'(op), 1'(c), ~1'(c));
                chk("reg_we", {15'h0000, reg_we_out}, {15'h0000, e[0]});
                if (e[0]) chk("reg_data", {8'h00, reg_wdata_out}, {8'h00, e[10:3]});
                chk("carry", {15'h0000, carry_out}, {15'h0000, e[2]});
                chk("zero", {15'h0000, zero_out}, {15'h0000, e[1]});
                chk("flags_we", {15'h0000, flags_we_out}, 16'h0001);
            end
        end
        $display("register operand test done");
    endtask : t_reg_ops
    task automatic t_reg_bitno;
        do_op(4'h0, 1'b0, 1'b1, 3'h6, 8'hF9, 8'h00, 4'h0, 1'b0, 2'h0, 1'b0);
        chk("reg_bitno", {8'h00, reg_wdata_out}, 16'h0002);
        do_op(4'h5, 1'b0, 1'b1, 3'h0, 8'h01, 8'h00, 4'h0, 1'b1, 2'h0, 1'b0);
        chk("illegal", {15'h0000, illegal_out}, 16'h0001);
        chk("illegal_flags", {15'h0000, flags_we_out}, 16'h0000);
        $display("bit number source test done");
    endtask : t_reg_bitno
    task automatic t_mem_ops;
        for (int op = 0; op < 14; op++) begin
            m0 = 8'h3C ^ 8'(op);
            bus.mem[op] = m0;
            w0 = bus.writes;
            do_op(4'(op), 1'b1, 1'b0, 3'(op + 3), 8'h00, 8'h00, 4'(op), 1'(op), 2'(op), 1'b0);
            e = exp_calc(4'(op), m0, 3'(op + 3), 1'(op), ~1'(op));
            chk("mem_byte", {8'h00, bus.mem[op]}, {8'h00, e[10:3]});
            chk("mem_writes", {8'h00, bus.writes - w0}, {15'h0000, e[0]});
            chk("mem_carry", {14'h0000, carry_out, zero_out}, {14'h0000, e[2:1]});
            chk("mem_addr", mem_addr_out, {12'h000, 4'(op)});
        end
        $display("memory operand test done");
    endtask : t_mem_ops
    task automatic t_write_only;
        bus.mem[15] = 8'h3F;
        do_op(4'h1, 1'b1, 1'b0, 3'h0, 8'h00, 8'h00, 4'hF, 1'b0, 2'h1, 1'b1);
        chk("write_only", {8'h00, bus.mem[15]}, 16'h00FE);
        $display("write-only test done");
    endtask : t_write_only
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        {arst_n_in, start_in, use_reg_bitno_in, mem_operand_in, carry_in, zero_in, wo_on} = 7'h00;
        {op_in, imm_bitno_in, bus_wait, reg_bitno_in, reg_data_in, addr_in} = 41'h000;
        repeat (8) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        t_reg_ops();
        t_reg_bitno();
        t_mem_ops();
        t_write_only();
        results();
    end
    // watchdog
    initial begin
        #(4000 * 100);
        err_total++;
        results();
    end
endmodule : test_cpu_bit_manipulation_unit
